/* design/albk_defines.svh */
// Register offsets, field positions and reset values for loopback/encoded tx
`ifndef ALBK_DEFINES_SVH
`define ALBK_DEFINES_SVH

`define ALBK_ADDR_W 8
`define ALBK_OFF_LOOPBACK 8'h4C
`define ALBK_OFF_ENCODED 8'h50
`define ALBK_OFF_GLOBAL 8'h44

`define ALBK_LB_EN_BIT 0
`define ALBK_LB_ORD_BIT 1
`define ALBK_LB_GEN_LO 2
`define ALBK_LB_GEN_HI 3
`define ALBK_ET_EN_BIT 0
`define ALBK_ET_VA_BIT 2
`define ALBK_ET_VB_BIT 3

`define ALBK_GL_CLKRST_BIT 0
`define ALBK_GL_HCLKRST_BIT 1
`define ALBK_GL_SRCLR_BIT 2
`define ALBK_GL_SMRST_BIT 3

`define ALBK_GEN_NONE 2'h0
`define ALBK_GEN_TX 2'h1
`define ALBK_NSER 16
`define ALBK_ZERO32 32'h00000000

`endif

/* design/albk_pkg.sv */
// Types shared by the loopback and encoded transmit control block
package albk_pkg;

    // Clock and frame sync source seen by the receive section
    typedef enum logic [1:0] {
        ALBK_SRC_OWN,
        ALBK_SRC_TX
    } albk_src_t;

    // Transmitter operating mode
    typedef enum logic [1:0] {
        ALBK_MODE_TDM,
        ALBK_MODE_ENCODED
    } albk_mode_t;

    // Transmit state machine phase behind the state machine reset output
    typedef enum logic [1:0] {
        ALBK_TX_HELD,
        ALBK_TX_RUN
    } albk_txst_t;

endpackage : albk_pkg

/* design/albk_route.sv */
// Loopback crossbar that steers transmit data into paired receivers
`timescale 1ns/10ps
`default_nettype none
`include "albk_defines.svh"

module albk_route (
    input wire logic clk,
    input wire logic rst,
    input wire logic loop_on,
    input wire logic pair_order,
    input wire logic [`ALBK_NSER-1:0] tx_bits,
    input wire logic [`ALBK_NSER-1:0] pin_bits,
    output logic [`ALBK_NSER-1:0] rx_bits
);

    // One pair of serializers per loop, a single direction chosen by order
    genvar p;
    generate
        for (p = 0; p < `ALBK_NSER / 2; p = p + 1) begin : g_pair
            // Registered so the receiver sees a clean sample each cycle
            always_ff @(posedge clk) begin
                if (rst) begin
                    rx_bits[2*p] <= 1'b0;
                    rx_bits[2*p+1] <= 1'b0;
                end else if (!loop_on) begin
                    rx_bits[2*p] <= pin_bits[2*p];
                    rx_bits[2*p+1] <= pin_bits[2*p+1];
                end else if (!pair_order) begin
                    rx_bits[2*p] <= tx_bits[2*p+1];
                    rx_bits[2*p+1] <= pin_bits[2*p+1];
                end else begin
                    rx_bits[2*p] <= pin_bits[2*p];
                    rx_bits[2*p+1] <= tx_bits[2*p];
                end
            end
        end
    endgenerate

endmodule : albk_route
`default_nettype wire

/* design/albk_ctrl.sv */
// Loopback and encoded transmit control registers with routing
`timescale 1ns/10ps
`default_nettype none
`include "albk_defines.svh"

// Functional notes
// - Loopback routes tx serializers into receivers
// - Bit 0 enables loopback
// - Generator field only counts with loopback
// - Mode 01 shares transmit clock generators
// - Order 0: odd feeds even
// - Order 1: even feeds odd
// - Unused bits read zero, ignore writes
// - Right subframe valid flag from bit 3
// - Left subframe valid flag from bit 2
// - Enable 0 gives TDM or burst
// - Enable 1 gives biphase encoded mode
// - Dividers need not be in reset
// - State machine reset active at 0
module albk_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic [`ALBK_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic slot_odd,
    input wire logic [`ALBK_NSER-1:0] tx_bits,
    input wire logic [`ALBK_NSER-1:0] pin_bits,
    output logic [31:0] reg_rdata,
    output logic [`ALBK_NSER-1:0] rx_bits,
    output logic rx_use_tx_clocks,
    output logic encoded_transmit_mode,
    output logic subframe_valid_flag,
    output logic tx_state_machine_reset,
    output logic tx_serializer_clear,
    output logic tx_clock_divider_reset,
    output logic tx_high_freq_divider_reset
);

    // Loopback control fields
    logic loopback_enable;
    logic loopback_pair_order;
    logic [1:0] loopback_gen;
    // Encoded transmit control fields
    logic encoded_transmit_enable;
    logic left_subframe_valid_flag;
    logic right_subframe_valid_flag;
    // Transmit side of the global control word, all low after reset
    logic [3:0] global_control;
    // Phase of the transmit state machine
    albk_pkg::albk_txst_t tx_phase;
    // Decoded writes
    logic wr_loop;
    logic wr_enc;
    logic wr_glob;
    // Loop active whenever the enable bit is set
    logic loop_live;

    assign wr_loop = reg_wr && (reg_addr == `ALBK_OFF_LOOPBACK);
    assign wr_enc = reg_wr && (reg_addr == `ALBK_OFF_ENCODED);
    assign wr_glob = reg_wr && (reg_addr == `ALBK_OFF_GLOBAL);
    // Generator value does not affect routing, enable alone decides
    assign loop_live = loopback_enable;

    // Loopback register, only bits 3-0 are stored
    always_ff @(posedge clk) begin
        if (rst) begin
            loopback_enable <= 1'b0;
            loopback_pair_order <= 1'b0;
            loopback_gen <= `ALBK_GEN_NONE;
        end else if (wr_loop) begin
            loopback_enable <= reg_wdata[`ALBK_LB_EN_BIT];
            loopback_pair_order <= reg_wdata[`ALBK_LB_ORD_BIT];
            loopback_gen <=
                reg_wdata[`ALBK_LB_GEN_HI:`ALBK_LB_GEN_LO];
        end
    end

    // Transmit global bits; divider resets live here too
    always_ff @(posedge clk) begin
        if (rst) begin
            global_control <= 4'h0;
        end else if (wr_glob) begin
            global_control <= reg_wdata[3:0];
        end
    end

    // State machine phase follows its reset bit, low holds it
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_phase <= albk_pkg::ALBK_TX_HELD;
        end else begin
            case (global_control[`ALBK_GL_SMRST_BIT])
                1'b0: tx_phase <= albk_pkg::ALBK_TX_HELD;
                1'b1: tx_phase <= albk_pkg::ALBK_TX_RUN;
                default: tx_phase <= albk_pkg::ALBK_TX_HELD;
            endcase
        end
    end

    // Encoded register; enable taken regardless of divider resets
    // and of the state machine reset, which does not gate a mode change
    always_ff @(posedge clk) begin
        if (rst) begin
            encoded_transmit_enable <= 1'b0;
            left_subframe_valid_flag <= 1'b0;
            right_subframe_valid_flag <= 1'b0;
        end else if (wr_enc) begin
            encoded_transmit_enable <= reg_wdata[`ALBK_ET_EN_BIT];
            left_subframe_valid_flag <= reg_wdata[`ALBK_ET_VA_BIT];
            right_subframe_valid_flag <= reg_wdata[`ALBK_ET_VB_BIT];
        end
    end

    // Mode output; a write while running still shows, software's duty
    always_ff @(posedge clk) begin
        if (rst) begin
            encoded_transmit_mode <= 1'b0;
        end else begin
            encoded_transmit_mode <= encoded_transmit_enable;
        end
    end

    // Valid flag per subframe: odd slot right, even slot left
    always_ff @(posedge clk) begin
        if (rst) begin
            subframe_valid_flag <= 1'b0;
        end else if (slot_odd) begin
            subframe_valid_flag <= right_subframe_valid_flag;
        end else begin
            subframe_valid_flag <= left_subframe_valid_flag;
        end
    end

    // Receive clock source: generator field counts only in loopback
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_use_tx_clocks <= 1'b0;
        end else begin
            rx_use_tx_clocks <= loopback_enable
                && (loopback_gen == `ALBK_GEN_TX);
        end
    end

    // Global reset controls driven out registered
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_state_machine_reset <= 1'b0;
            tx_serializer_clear <= 1'b0;
            tx_clock_divider_reset <= 1'b0;
            tx_high_freq_divider_reset <= 1'b0;
        end else begin
            tx_state_machine_reset <=
                (tx_phase == albk_pkg::ALBK_TX_RUN);
            tx_serializer_clear <= global_control[`ALBK_GL_SRCLR_BIT];
            tx_clock_divider_reset <= global_control[`ALBK_GL_CLKRST_BIT];
            tx_high_freq_divider_reset <=
                global_control[`ALBK_GL_HCLKRST_BIT];
        end
    end

    // Read data one cycle after the strobe, unmapped reads zero
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= `ALBK_ZERO32;
        end else if (reg_rd) begin
            case (reg_addr)
                `ALBK_OFF_LOOPBACK: reg_rdata <= {28'h0000000,
                    loopback_gen, loopback_pair_order,
                    loopback_enable};
                `ALBK_OFF_ENCODED: reg_rdata <= {28'h0000000,
                    right_subframe_valid_flag, left_subframe_valid_flag,
                    1'b0, encoded_transmit_enable};
                `ALBK_OFF_GLOBAL: reg_rdata <= {28'h0000000,
                    global_control};
                default: reg_rdata <= `ALBK_ZERO32;
            endcase
        end else begin
            reg_rdata <= `ALBK_ZERO32;
        end
    end

    // Serializer pairing in loopback
    albk_route u_route (
        .clk(clk),
        .rst(rst),
        .loop_on(loop_live),
        .pair_order(loopback_pair_order),
        .tx_bits(tx_bits),
        .pin_bits(pin_bits),
        .rx_bits(rx_bits)
    );

endmodule : albk_ctrl
`default_nettype wire

/* bench/albk_ctrl_assertions.sv */
// Port checker for the loopback and encoded transmit controls
`timescale 1ns/10ps
`default_nettype none
`include "albk_defines.svh"
module albk_ctrl_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic slot_odd,
    input wire logic [15:0] tx_bits,
    input wire logic [15:0] pin_bits,
    input wire logic [31:0] reg_rdata,
    input wire logic [15:0] rx_bits,
    input wire logic rx_use_tx_clocks,
    input wire logic encoded_transmit_mode,
    input wire logic subframe_valid_flag,
    input wire logic tx_state_machine_reset,
    input wire logic tx_serializer_clear,
    input wire logic tx_clock_divider_reset,
    input wire logic tx_high_freq_divider_reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [3:0] lb, et, gl; // Shadows of the writable fields
    logic [31:0] rview; // Expected read answer
    // Shadow registers follow software writes
    always_ff @(posedge clk) begin
        if (rst) begin
            {lb, et, gl} <= 12'h000;
        end else if (reg_wr) begin
            if (reg_addr == `ALBK_OFF_LOOPBACK) lb <= reg_wdata[3:0];
            if (reg_addr == `ALBK_OFF_ENCODED) et <= reg_wdata[3:0] & 4'hD;
            if (reg_addr == `ALBK_OFF_GLOBAL) gl <= reg_wdata[3:0];
        end
    end
    assign rview = (reg_addr == `ALBK_OFF_LOOPBACK) ? {28'h0, lb} :
        (reg_addr == `ALBK_OFF_ENCODED) ? {28'h0, et} : 32'h0;
    // Pair steering; the other bit of a pair keeps its pin
    function automatic logic [15:0] route(logic [3:0] l, logic [15:0] t, p);
        for (int i = 0; i < 16; i += 2) begin
            if (l[0] && !l[1]) p[i] = t[i+1];
            if (l[0] && l[1]) p[i+1] = t[i];
        end
        return p;
    endfunction : route
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside answer cycle");
    read_back_a: assert property ($past(reg_rd) &&
        $past(reg_addr) != `ALBK_OFF_GLOBAL |-> reg_rdata == $past(rview))
        else $error("read data wrong");
    route_match_a: assert property (!$past(rst) |->
        rx_bits == $past(route(lb, tx_bits, pin_bits))) else $error("route");
    tx_clocks_a: assert property (!$past(rst) |-> rx_use_tx_clocks ==
        $past(lb[0] && lb[3:2] == 2'h1)) else $error("clock source");
    enc_mode_a: assert property (!$past(rst) |->
        encoded_transmit_mode == $past(et[0])) else $error("mode");
    valid_flag_a: assert property (!$past(rst) |-> subframe_valid_flag ==
        $past(slot_odd ? et[3] : et[2])) else $error("valid flag");
    divider_copy_a: assert property (!$past(rst) |-> {tx_serializer_clear,
        tx_high_freq_divider_reset, tx_clock_divider_reset} == $past(gl[2:0]))
        else $error("divider controls");
    sm_reset_a: assert property (!$past(rst) && !$past(rst, 2) |->
        tx_state_machine_reset == $past(gl[3], 2)) else $error("sm reset");
endmodule : albk_ctrl_checker
bind albk_ctrl albk_ctrl_checker i_chk (.*);
`default_nettype wire

/* bench/test_audio_loopback_and_spdif_tx_control.sv */
// Self-checking bench for the loopback and encoded transmit controls
`timescale 1ns/10ps
`default_nettype none
`include "albk_defines.svh"
module test_audio_loopback_and_spdif_tx_control;
    logic clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
    logic slot_odd = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [15:0] tx_bits = 16'h00FF, pin_bits = 16'h0F0F, rx_bits;
    logic use_tx, mode, vflag, smr, sclr, cdr, hdr;
    int num_errors = 0, comparisons = 0;
    // Write value, expected rx, readback, clock source
    localparam logic [52:0] ROWS [6] = '{
        {32'hFFFFFFF0, 16'h0F0F, 4'h0, 1'h0},
        {32'h00000005, 16'h0A5F, 4'h5, 1'h1},
        {32'h00000007, 16'h05AF, 4'h7, 1'h1},
        {32'h0000000D, 16'h0A5F, 4'hD, 1'h0},
        {32'h00000001, 16'h0A5F, 4'h1, 1'h0},
        {32'h00000004, 16'h0F0F, 4'h4, 1'h0}};
    localparam logic [3:0] ET [3] = '{4'h9, 4'h4, 4'hD};
    initial forever #5 clk = ~clk;
    albk_ctrl i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .slot_odd(slot_odd), .tx_bits(tx_bits), .pin_bits(pin_bits),
        .reg_rdata(reg_rdata), .rx_bits(rx_bits), .rx_use_tx_clocks(use_tx),
        .encoded_transmit_mode(mode), .subframe_valid_flag(vflag),
        .tx_state_machine_reset(smr), .tx_serializer_clear(sclr),
        .tx_clock_divider_reset(cdr), .tx_high_freq_divider_reset(hdr));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One bus cycle; a read compares its answer with d
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge clk);
        {reg_wr, reg_rd} <= 2'h0;
        #1;
        if (!w) chk(reg_rdata, d);
    endtask : bus
    // Margin for the registered outputs to settle
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    task automatic give_verdict;
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #20000;
        num_errors++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        foreach (ROWS[i]) begin
            bus(1'h1, `ALBK_OFF_LOOPBACK, ROWS[i][52:21]);
            settle(3);
            chk(32'(rx_bits), 32'(ROWS[i][20:5]));
            chk(32'(use_tx), 32'(ROWS[i][0]));
            bus(1'h0, `ALBK_OFF_LOOPBACK, 32'(ROWS[i][4:1]));
        end
        $display("loopback rows done");
        bus(1'h1, `ALBK_OFF_ENCODED, 32'hFFFFFFFF);
        bus(1'h0, `ALBK_OFF_ENCODED, 32'h0000000D);
        foreach (ET[k]) begin
            bus(1'h1, `ALBK_OFF_ENCODED, 32'(ET[k]));
            for (int s = 0; s < 2; s++) begin
                @(posedge clk) slot_odd <= s[0];
                settle(2);
                chk(32'(vflag), 32'(ET[k][2 + s]));
            end
            chk(32'(mode), 32'(ET[k][0]));
        end
        $display("encoded mode done");
        // Dividers running, state machine held, mode change accepted
        bus(1'h1, `ALBK_OFF_GLOBAL, 32'h00000003);
        bus(1'h1, `ALBK_OFF_ENCODED, 32'h00000000);
        settle(3);
        chk(32'({smr, sclr, hdr, cdr}), 32'h3);
        chk(32'(mode), 32'h0);
        bus(1'h1, `ALBK_OFF_GLOBAL, 32'h0000000C);
        settle(3);
        chk(32'({smr, sclr, hdr, cdr}), 32'hC);
        bus(1'h0, 8'h10, 32'h0);
        $display("global controls done");
        // Reset in mid-run clears every field
        @(posedge clk) rst <= 1'h1;
        settle(2);
        @(posedge clk) rst <= 1'h0;
        bus(1'h0, `ALBK_OFF_LOOPBACK, 32'h0);
        bus(1'h0, `ALBK_OFF_ENCODED, 32'h0);
        chk(32'({mode, smr, use_tx}), 32'h0);
        $display("reset test done");
        give_verdict();
    end
endmodule : test_audio_loopback_and_spdif_tx_control
`default_nettype wire
